// >>> rtc_pin_pkg.sv
// Package with constants and carrier types for the RTC pin interface logic.
// Functional notes
// R01 - Sample the protocol strap: low selects 3-wire, high selects SPI.
// R02 - Host holds chip enable high throughout every read or write transfer.
// R03 - Serial clock edges alone time data in and out, both modes.
// R04 - 3-wire joins data in and out into one line; SPI keeps them separate.
// R05 - In 3-wire mode drive data only for read data; release otherwise.
// R06 - First interrupt answers alarm A only, or either alarm, by configuration.
// R07 - Interrupt stays low while its flag and enable are both set.
// R08 - Second interrupt, in interrupt use, is asserted only by alarm B.
// R09 - Second interrupt may instead emit the timekeeping square wave.
// R10 - Both interrupts are open-drain, active low, never driven high.
// R11 - Power-fail output is low whenever main supply is below threshold.
// R12 - Below the power-fail threshold all serial register access is blocked.
package rtc_pin_pkg;

  localparam logic STRAP_3WIRE = 1'h0;
  localparam logic STRAP_SPI   = 1'h1;

  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_ZERO = 3'h0;

  // Bit in the command byte that marks a read when clear.
  localparam int unsigned RW_BIT = 7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CMD  = 2'h1,
    ST_DATA = 2'h3
  } serial_state_type;

  typedef struct packed {
    logic chipEnable;
    logic serialClock;
    logic dataIn;
  } link_in_type;

  typedef struct packed {
    logic alarmFlagA;
    logic alarmFlagB;
    logic alarmEnableA;
    logic alarmEnableB;
    logic combineAlarms;
    logic squareWaveSel;
    logic squareWave;
    logic supplyLow;
  } status_in_type;

endpackage

// >>> sync2.sv
// Two-stage synchroniser for a bundle of asynchronous level inputs.
`timescale 1ns/1ps
module sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  // The first stage feeds only the second one, so metastability cannot spread.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;

endmodule

// >>> rtc_pin_interface_logic.sv
// Pin-level serial link, interrupt and power-fail logic of the real-time clock.
`timescale 1ns/1ps
module rtc_pin_interface_logic (
  input  wire logic                        core_clk,
  input  wire logic                        srst,
  input  wire logic                        serial_protocol_strap,
  input  wire rtc_pin_pkg::link_in_type    linkIn,
  input  wire rtc_pin_pkg::status_in_type  statusIn,
  input  wire logic [7:0]                  readByte,
  output logic                             spiMode,
  output logic                             dataOut,
  output logic                             dataOutEn_n,
  output logic                             alarm_irq_a_n,
  output logic                             alarm_irq_a_oe_n,
  output logic                             alarm_irq_b_n,
  output logic                             alarm_irq_b_oe_n,
  output logic                             power_fail_n,
  output logic                             accessBlocked,
  output logic [7:0]                       rxByte,
  output logic                             rxValid,
  output logic                             txTake
);

  // One strap bit, the three link pins and the eight status levels all pass the synchroniser.
  localparam int unsigned SYNC_W = 1 + $bits(rtc_pin_pkg::link_in_type) + $bits(rtc_pin_pkg::status_in_type);

  typedef struct packed {
    logic [1:0]                    settle;
    logic                          strapTaken;
    logic                          spiSel;
    logic                          sclkPrev;
    rtc_pin_pkg::serial_state_type state;
    logic [2:0]                    bitCnt;
    logic [7:0]                    shiftIn;
    logic [7:0]                    shiftOut;
    logic                          readXfer;
    logic                          doutBit;
    logic                          doutEn_n;
    logic                          irqA_oe_n;
    logic                          irqB_oe_n;
    logic                          pf_n;
    logic                          blocked;
    logic [7:0]                    rxData;
    logic                          rxPulse;
    logic                          takePulse;
  } state_type;

  logic [SYNC_W-1:0] rawIn;
  logic [SYNC_W-1:0] syncIn;
  state_type         cur_ff;
  state_type         nxt_cur;
  logic              ce;
  logic              sclk;
  logic              din;
  logic              strap;
  logic              flagA;
  logic              flagB;
  logic              enA;
  logic              enB;
  logic              combine;
  logic              sqSel;
  logic              sqWave;
  logic              supplyLow;
  logic              sclkRise;
  logic              sclkFall;
  logic              irqACause;
  logic              irqBCause;

  assign rawIn = {serial_protocol_strap, linkIn, statusIn};

  sync2 #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .asyncIn  (rawIn),
    .syncOut  (syncIn)
  );

  assign {strap, ce, sclk, din, flagA, flagB, enA, enB, combine, sqSel, sqWave, supplyLow} = syncIn;

  // Serial clock edges are found by sampling, so the core clock must run well above the link clock.
  assign sclkRise = sclk & ~cur_ff.sclkPrev;  // [R03]
  assign sclkFall = ~sclk & cur_ff.sclkPrev;  // [R03]

  // Alarm A alone, or both alarms merged, drive the first interrupt.
  assign irqACause = (flagA & enA) | (combine & flagB & enB);  // [R06] [R07]
  assign irqBCause = flagB & enB;                              // [R08] [R07]

  always_comb begin
    nxt_cur           = cur_ff;
    nxt_cur.sclkPrev  = sclk;
    nxt_cur.rxPulse   = 1'h0;
    nxt_cur.takePulse = 1'h0;
    // The synchroniser is cleared by reset, so the strap is caught only once both stages hold it again.
    // Later changes of the strap are ignored until the next reset.
    nxt_cur.settle = {cur_ff.settle[0], 1'h1};
    if (cur_ff.settle[1] && !cur_ff.strapTaken) begin
      nxt_cur.strapTaken = 1'h1;
      nxt_cur.spiSel     = (strap == rtc_pin_pkg::STRAP_SPI);  // [R01]
    end
    nxt_cur.pf_n      = ~supplyLow;  // [R11]
    nxt_cur.blocked   = supplyLow;   // [R12]
    nxt_cur.irqA_oe_n = ~irqACause;  // [R10]
    if (sqSel) begin
      nxt_cur.irqB_oe_n = sqWave;    // [R09] [R10]
    end else begin
      nxt_cur.irqB_oe_n = ~irqBCause;  // [R10]
    end
    if (!ce || supplyLow) begin
      // Losing chip enable ends the frame; a supply drop aborts it.
      nxt_cur.state    = rtc_pin_pkg::ST_IDLE;  // [R02] [R12]
      nxt_cur.bitCnt   = rtc_pin_pkg::BIT_ZERO;
      nxt_cur.readXfer = 1'h0;
      nxt_cur.doutEn_n = 1'h1;     // [R05]
    end else begin
      if (cur_ff.state == rtc_pin_pkg::ST_IDLE) begin
        nxt_cur.state = rtc_pin_pkg::ST_CMD;
      end
      if (sclkRise) begin
        nxt_cur.shiftIn = {cur_ff.shiftIn[6:0], din};  // [R03]
        nxt_cur.bitCnt  = cur_ff.bitCnt + 3'h1;
        if (cur_ff.bitCnt == rtc_pin_pkg::BIT_LAST) begin
          nxt_cur.rxData  = {cur_ff.shiftIn[6:0], din};
          nxt_cur.rxPulse = 1'h1;
          if (cur_ff.state != rtc_pin_pkg::ST_DATA) begin
            nxt_cur.state    = rtc_pin_pkg::ST_DATA;
            nxt_cur.readXfer = ~cur_ff.shiftIn[rtc_pin_pkg::RW_BIT - 1];
          end
          if (nxt_cur.readXfer) begin
            nxt_cur.shiftOut  = readByte;
            nxt_cur.takePulse = 1'h1;
          end
        end
      end
      if (sclkFall && cur_ff.readXfer) begin
        nxt_cur.doutBit  = cur_ff.shiftOut[7];  // [R03]
        nxt_cur.shiftOut = {cur_ff.shiftOut[6:0], 1'h0};
      end
      // SPI owns a separate output; 3-wire shares the line and drives it only for read data.
      nxt_cur.doutEn_n = ~(cur_ff.readXfer && cur_ff.state == rtc_pin_pkg::ST_DATA);  // [R04] [R05]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      cur_ff <= '{settle: 2'h0, strapTaken: 1'h0, spiSel: 1'h0, sclkPrev: 1'h0, state: rtc_pin_pkg::ST_IDLE,
                  bitCnt: 3'h0, shiftIn: 8'h00, shiftOut: 8'h00, readXfer: 1'h0,
                  doutBit: 1'h0, doutEn_n: 1'h1, irqA_oe_n: 1'h1, irqB_oe_n: 1'h1,
                  pf_n: 1'h1, blocked: 1'h0, rxData: 8'h00, rxPulse: 1'h0, takePulse: 1'h0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign spiMode          = cur_ff.spiSel;
  assign dataOut          = cur_ff.doutBit;
  assign dataOutEn_n      = cur_ff.doutEn_n;
  assign alarm_irq_a_n    = 1'h0;  // [R10]
  assign alarm_irq_a_oe_n = cur_ff.irqA_oe_n;
  assign alarm_irq_b_n    = 1'h0;  // [R10]
  assign alarm_irq_b_oe_n = cur_ff.irqB_oe_n;
  assign power_fail_n     = cur_ff.pf_n;
  assign accessBlocked    = cur_ff.blocked;
  assign rxByte           = cur_ff.rxData;
  assign rxValid          = cur_ff.rxPulse;
  assign txTake           = cur_ff.takePulse;

  property p_strap_sampled;
    @(posedge core_clk) disable iff (srst)
    $rose(cur_ff.strapTaken) |-> spiMode == ($past(strap) == rtc_pin_pkg::STRAP_SPI);
  endproperty
  a_strap_sampled: assert property (p_strap_sampled) else $error("Strap not captured."); // [R01]

  property p_release_on_ce_low;
    @(posedge core_clk) disable iff (srst)
    !ce |=> dataOutEn_n;
  endproperty
  a_release_on_ce_low: assert property (p_release_on_ce_low) else $error("Data driven without chip enable."); // [R05]

  property p_drive_only_read;
    @(posedge core_clk) disable iff (srst)
    !dataOutEn_n |-> $past(cur_ff.readXfer);
  endproperty
  a_drive_only_read: assert property (p_drive_only_read) else $error("Data driven outside a read."); // [R05]

  property p_irq_a_follows;
    @(posedge core_clk) disable iff (srst)
    alarm_irq_a_oe_n == !$past(irqACause);
  endproperty
  a_irq_a_follows: assert property (p_irq_a_follows) else $error("First interrupt mismatch."); // [R07]

  property p_irq_a_combine;
    @(posedge core_clk) disable iff (srst)
    (!combine && !(flagA && enA)) ##1 !combine |-> alarm_irq_a_oe_n;
  endproperty
  a_irq_a_combine: assert property (p_irq_a_combine) else $error("Second alarm leaked onto first."); // [R06]

  property p_irq_b_only_b;
    @(posedge core_clk) disable iff (srst)
    (!sqSel && !(flagB && enB)) |=> alarm_irq_b_oe_n;
  endproperty
  a_irq_b_only_b: assert property (p_irq_b_only_b) else $error("Second interrupt without alarm B."); // [R08]

  property p_square_wave;
    @(posedge core_clk) disable iff (srst)
    sqSel |=> alarm_irq_b_oe_n == $past(sqWave);
  endproperty
  a_square_wave: assert property (p_square_wave) else $error("Square wave not passed."); // [R09]

  property p_open_drain;
    @(posedge core_clk) disable iff (srst)
    !alarm_irq_a_n && !alarm_irq_b_n;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("Interrupt driven high."); // [R10]

  property p_power_fail;
    @(posedge core_clk) disable iff (srst)
    supplyLow |=> !power_fail_n ##0 accessBlocked;
  endproperty
  a_power_fail: assert property (p_power_fail) else $error("Power-fail not flagged."); // [R11]

  property p_block_access;
    @(posedge core_clk) disable iff (srst)
    supplyLow |=> !rxValid && dataOutEn_n;
  endproperty
  a_block_access: assert property (p_block_access) else $error("Access during power fail."); // [R12]

  c_byte_rx: cover property (@(posedge core_clk) disable iff (srst) rxValid);
  c_read_drive: cover property (@(posedge core_clk) disable iff (srst) !dataOutEn_n);
  c_irq_both: cover property (@(posedge core_clk) disable iff (srst) !alarm_irq_a_oe_n && !alarm_irq_b_oe_n);
  c_pf: cover property (@(posedge core_clk) disable iff (srst) !power_fail_n);

endmodule

// >>> rtc_host_model.sv
// Behavioural host with an SPI or 3-wire serial port for the RTC pin logic.
`timescale 1ns/1ps
module rtc_host_model (
  input  wire logic                 core_clk,
  input  wire logic                 threeWire,
  input  wire logic                 dataOut,
  input  wire logic                 dataOutEn_n,
  output rtc_pin_pkg::link_in_type  linkIn
);
  logic hostBit   = 1'h0;
  logic hostDrive = 1'h0;
  logic lastLine  = 1'h0;
  logic ce        = 1'h0;
  logic sclk      = 1'h1;
  logic lineLevel;
  // A released line shows a pattern that changes every cycle, so stale data cannot pass for a reply.
  assign lineLevel = hostDrive ? hostBit : (!dataOutEn_n ? dataOut : ~lastLine);
  assign linkIn = '{ce, sclk, lineLevel};
  always @(posedge core_clk) lastLine <= lineLevel;
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Chip enable rises before the first clock edge and stays high to the end.
  task automatic frame_begin();
    @(posedge core_clk);
    ce <= 1'h1;
    hostDrive <= 1'h1;
    wait_cycles(4);
  endtask
  task automatic frame_end();
    wait_cycles(4);
    ce <= 1'h0;
    hostDrive <= 1'h0;
    wait_cycles(6);
  endtask
  // The clock idles high and stands still between frames; data moves only on its edges.
  task automatic xfer(input logic [7:0] txByte, input logic readBack, output logic [7:0] inByte);
    for (int i = 7; i >= 0; i--) begin
      @(posedge core_clk);
      sclk <= 1'h0;
      hostBit <= txByte[i];
      hostDrive <= !(readBack && threeWire);
      wait_cycles(4);
      sclk <= 1'h1;
      inByte[i] = threeWire ? lineLevel : dataOut;
      wait_cycles(3);
    end
  endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the RTC pin interface logic.
`timescale 1ns/1ps
module tb_top;
  logic                       core_clk = 1'h0;
  logic                       srst     = 1'h1;
  logic                       strap    = 1'h1;
  logic [7:0]                 readByte = 8'hC5;
  rtc_pin_pkg::status_in_type statusIn = '0;
  rtc_pin_pkg::status_in_type s;
  rtc_pin_pkg::link_in_type   linkIn;
  logic [7:0]                 rxByte, got;
  logic                       spiMode, dataOut, dataOutEn_n, irqA, irqAOe_n, irqB, irqBOe_n;
  logic                       power_fail_n, accessBlocked, rxValid, txTake;
  logic [7:0]                 rxLog[$];
  int                         drvCount = 0;
  int                         fails = 0;
  int                         total_checks = 0;
  int                         n0, d0;
  initial forever #2 core_clk = ~core_clk;
  rtc_pin_interface_logic dut_u (.core_clk(core_clk), .srst(srst), .serial_protocol_strap(strap),
    .linkIn(linkIn), .statusIn(statusIn), .readByte(readByte), .spiMode(spiMode), .dataOut(dataOut),
    .dataOutEn_n(dataOutEn_n), .alarm_irq_a_n(irqA), .alarm_irq_a_oe_n(irqAOe_n), .alarm_irq_b_n(irqB),
    .alarm_irq_b_oe_n(irqBOe_n), .power_fail_n(power_fail_n), .accessBlocked(accessBlocked),
    .rxByte(rxByte), .rxValid(rxValid), .txTake(txTake));
  rtc_host_model host_u (.core_clk(core_clk), .threeWire(!strap), .dataOut(dataOut),
    .dataOutEn_n(dataOutEn_n), .linkIn(linkIn));
  always @(posedge core_clk) begin
    if (rxValid === 1'h1) rxLog.push_back(rxByte);
    if (dataOutEn_n === 1'h0) drvCount++;
  end
  task automatic check1(input logic g, input logic e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic check8(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic do_reset(input logic mode);
    @(posedge core_clk);
    strap <= mode;
    srst <= 1'h1;
    repeat (16) @(posedge core_clk);
    srst <= 1'h0;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic set_status(input rtc_pin_pkg::status_in_type v);
    @(posedge core_clk);
    statusIn <= v;
    repeat (5) @(posedge core_clk);
  endtask
  // Command byte with bit 7 clear asks for a read; the second byte then carries the reply.
  task automatic frame(input logic [7:0] cmd, input logic [7:0] dat, input logic rd);
    n0 = rxLog.size();
    d0 = drvCount;
    host_u.frame_begin();
    host_u.xfer(cmd, 1'h0, got);
    host_u.xfer(dat, rd, got);
    host_u.frame_end();
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    do_reset(1'h1);
    check1(spiMode, 1'h1);
    check1(power_fail_n, 1'h1);
    for (int m = 0; m < 2; m++) begin
      if (m == 1) begin
        do_reset(1'h0);
        check1(spiMode, 1'h0);
      end
      frame(8'h2A, 8'h00, 1'h1);
      check8(rxLog[n0], 8'h2A);
      check8(got, 8'hC5);
      check1(dataOutEn_n, 1'h1);
      frame(8'hA5, 8'h3C, 1'h0);
      check8(rxLog[n0+1], 8'h3C);
      if (m == 1) check1(drvCount == d0, 1'h1);
    end
    set_status(8'h01);
    check1(power_fail_n, 1'h0);
    check1(accessBlocked, 1'h1);
    frame(8'hA5, 8'h3C, 1'h0);
    check1(rxLog.size() == n0, 1'h1);
    set_status(8'h00);
    check1(power_fail_n, 1'h1);
    // Every mix of flags, enables and modes is walked, the square wave level included.
    for (int k = 0; k < 128; k++) begin
      s = rtc_pin_pkg::status_in_type'({k[6:0], 1'h0});
      set_status(s);
      check1(irqAOe_n, !((s.alarmFlagA & s.alarmEnableA) | (s.combineAlarms & s.alarmFlagB & s.alarmEnableB)));
      check1(irqBOe_n, s.squareWaveSel ? s.squareWave : !(s.alarmFlagB & s.alarmEnableB));
      check1(irqA | irqB, 1'h0);
    end
    results();
  end
endmodule
